// *** hw/uebs_pkg.sv ***
// Package for the USB endpoint buffer status block: offsets, fields, types
package uebs_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_ABORT   = 8'h14;
    localparam logic [7:0] ADDR_SELECT  = 8'h18;
    localparam logic [7:0] ADDR_MODE    = 8'h1c;
    localparam logic [7:0] ADDR_FLAGS   = 8'h20;
    localparam logic [7:0] ADDR_ENABLES = 8'h24;
    localparam logic [7:0] ADDR_NAKCFG  = 8'h2c;

    // Widths and field positions
    localparam int         NUM_PHYS     = 10;
    localparam int         ABORT_W      = 30;
    localparam int         FIRST_DBL    = 2;
    localparam int         NAK_CO_BIT   = 0;
    localparam int         NAK_CI_BIT   = 1;
    localparam int         NAK_AO_BIT   = 2;
    localparam int         NAK_AI_BIT   = 3;

    // Reset values
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [9:0]  RESET_PHYS  = 10'h000;
    localparam logic [29:0] RESET_ABORT = 30'h0000_0000;

    // List memory: one word per buffer, two buffers per physical endpoint
    localparam int          LIST_AW     = 5;
    localparam int          ARMED_BIT   = 31;
    localparam int          COUNT_W     = 16;

    // One list entry as the sequencer sees it
    typedef struct packed {
        logic              armed;
        logic [14:0]       spare;
        logic [COUNT_W-1:0] count;
    } uebs_entry_s;

    // Events from the USB link side, one bit per physical endpoint except the single setup_ok bit
    typedef struct packed {
        logic [NUM_PHYS-1:0] count_zero;
        logic [NUM_PHYS-1:0] nak_sent;
        logic                setup_ok;
    } uebs_link_s;

    // Abort sequencer states
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_READ  = 4'b0010,
        SEQ_WAIT  = 4'b0100,
        SEQ_WRITE = 4'b1000
    } uebs_seq_e;

endpackage : uebs_pkg

// *** hw/uebs_list_mem.sv ***
// Endpoint command and status list memory, registered read data
`timescale 1ns/1ns
`default_nettype none
module uebs_list_mem (
    input  wire logic                        sys_clk,
    input  wire logic [uebs_pkg::LIST_AW-1:0] rd_addr,
    input  wire logic [uebs_pkg::LIST_AW-1:0] wr_addr,
    input  wire logic                        wr_en,
    input  wire logic [31:0]                 wr_data,
    output logic      [31:0]                 rd_data
);
    // Storage array; contents undefined until software fills it
    logic [31:0] mem [0:(1<<uebs_pkg::LIST_AW)-1];

    // Write port and registered read port
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : uebs_list_mem
`default_nettype wire

// *** hw/uebs_flag_bank.sv ***
// Sticky event flags with write-one-to-clear and interrupt gating
`timescale 1ns/1ns
`default_nettype none
module uebs_flag_bank (
    input  wire logic                         sys_clk,
    input  wire logic                         arst_n,
    input  wire logic [uebs_pkg::NUM_PHYS-1:0] set_evt,
    input  wire logic [uebs_pkg::NUM_PHYS-1:0] clr_mask,
    input  wire logic [uebs_pkg::NUM_PHYS-1:0] enables,
    output logic      [uebs_pkg::NUM_PHYS-1:0] flags,
    output logic                              irq
);
    logic [uebs_pkg::NUM_PHYS-1:0] next_flags;  // Flag next state
    logic                          next_irq;    // Interrupt next state

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        next_flags = (flags & ~clr_mask) | set_evt;
        next_irq   = |(next_flags & enables);
    end

    // Register flags and interrupt
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= uebs_pkg::RESET_PHYS;
            irq   <= 1'b0;
        end else begin
            flags <= next_flags;
            irq   <= next_irq;
        end
    end
endmodule : uebs_flag_bank
`default_nettype wire

// *** hw/uebs_top.sv ***
// Endpoint buffer control, abort sequencer and register file
`timescale 1ns/1ns
`default_nettype none
module uebs_top (
    input  wire logic                         sys_clk,
    input  wire logic                         arst_n,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_write,
    input  wire logic                         reg_read,
    input  wire uebs_pkg::uebs_link_s         link_evt,
    input  wire logic                         list_wr,
    input  wire logic [uebs_pkg::LIST_AW-1:0] list_addr,
    input  wire logic [31:0]                  list_wdata,
    output logic      [31:0]                  reg_rdata,
    output logic                              irq,
    output logic      [uebs_pkg::NUM_PHYS-1:0] buffer_done
);
    // Address decode used by the write paths; the read mux decodes with its own case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // Buffer index in list: endpoint times two plus buffer
    function automatic logic [uebs_pkg::LIST_AW-1:0] entry_idx(
        input logic [3:0] ep,
        input logic       buf_sel
    );
        entry_idx = {ep, buf_sel};
    endfunction : entry_idx

    // Register state
    logic [uebs_pkg::ABORT_W-1:0]  endpoint_abort_request;  // Pending aborts
    logic [uebs_pkg::NUM_PHYS-1:0] buffer_selector_state;   // Buffer in use
    logic [uebs_pkg::NUM_PHYS-1:0] buffer_mode_config;      // Double buffer
    logic [uebs_pkg::NUM_PHYS-1:0] endpoint_flag_enables;   // Interrupt gate
    logic [3:0]                    nak_notify;              // NAK options
    logic [uebs_pkg::ABORT_W-1:0]  next_abort;
    logic [uebs_pkg::NUM_PHYS-1:0] next_select;
    logic [uebs_pkg::NUM_PHYS-1:0] next_mode;
    logic [uebs_pkg::NUM_PHYS-1:0] next_enables;
    logic [3:0]                    next_nak;
    logic [31:0]                   next_rdata;

    // Sequencer state
    uebs_pkg::uebs_seq_e           seq_state;
    uebs_pkg::uebs_seq_e           next_seq_state;
    logic [3:0]                    seq_ep;        // Endpoint under service
    logic [3:0]                    next_seq_ep;
    logic                          seq_abort;     // Abort vs count-zero job
    logic                          next_seq_abort;
    logic [uebs_pkg::NUM_PHYS-1:0] zero_pend;     // Latched count-zero events
    logic [uebs_pkg::NUM_PHYS-1:0] next_zero_pend;
    logic [uebs_pkg::NUM_PHYS-1:0] next_done;

    // Memory and flag wiring
    logic [31:0]                   mem_rdata;
    logic [31:0]                   seq_wdata;
    logic                          seq_wr;
    logic [uebs_pkg::LIST_AW-1:0]  seq_addr;
    logic [uebs_pkg::NUM_PHYS-1:0] flag_set;
    logic [uebs_pkg::NUM_PHYS-1:0] flag_clr;
    logic [uebs_pkg::NUM_PHYS-1:0] flag_q;
    logic [uebs_pkg::NUM_PHYS-1:0] disarm_evt;
    logic [uebs_pkg::NUM_PHYS-1:0] nak_gate;
    uebs_pkg::uebs_entry_s         entry;
    logic                          wr_abort;
    logic                          wr_select;

    // List memory; sequencer always drives the read address and owns the write port in its write cycle, else software
    uebs_list_mem u_mem (
        .sys_clk (sys_clk),
        .rd_addr (seq_addr),
        .wr_addr (seq_wr ? seq_addr : list_addr),
        .wr_en   (seq_wr | list_wr),
        .wr_data (seq_wr ? seq_wdata : list_wdata),
        .rd_data (mem_rdata)
    );

    // Event flags with write-one-to-clear
    uebs_flag_bank u_flags (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .set_evt  (flag_set),
        .clr_mask (flag_clr),
        .enables  (endpoint_flag_enables),
        .flags    (flag_q),
        .irq      (irq)
    );

    // Strobe decode
    assign wr_abort  = reg_write && hit(reg_addr, uebs_pkg::ADDR_ABORT);
    assign wr_select = reg_write && hit(reg_addr, uebs_pkg::ADDR_SELECT);
    assign flag_clr  = (reg_write && hit(reg_addr, uebs_pkg::ADDR_FLAGS))
                     ? reg_wdata[uebs_pkg::NUM_PHYS-1:0] : '0;
    assign entry     = uebs_pkg::uebs_entry_s'(mem_rdata);

    // Per-endpoint NAK gate: even bits OUT, odd bits IN
    genvar g;
    generate
        for (g = 0; g < uebs_pkg::NUM_PHYS; g++) begin : g_nak
            if (g == 0) begin : g_co
                assign nak_gate[g] = nak_notify[uebs_pkg::NAK_CO_BIT];
            end else if (g == 1) begin : g_ci
                assign nak_gate[g] = nak_notify[uebs_pkg::NAK_CI_BIT];
            end else if (g % 2 == 0) begin : g_ao
                assign nak_gate[g] = nak_notify[uebs_pkg::NAK_AO_BIT];
            end else begin : g_ai
                assign nak_gate[g] = nak_notify[uebs_pkg::NAK_AI_BIT];
            end
        end
    endgenerate

    // Flag sources: disarm, gated NAK, SETUP on control OUT
    always_comb begin
        flag_set    = disarm_evt | (link_evt.nak_sent & nak_gate);
        flag_set[0] = flag_set[0] | link_evt.setup_ok;
    end

    // Abort sequencer: read entry, clear armed, write back
    always_comb begin
        next_seq_state = seq_state;
        next_seq_ep    = seq_ep;
        next_seq_abort = seq_abort;
        next_zero_pend = zero_pend | link_evt.count_zero;
        next_abort     = endpoint_abort_request;
        next_select    = buffer_selector_state;
        next_done      = '0;
        disarm_evt     = '0;
        seq_wr         = 1'b0;
        seq_addr       = entry_idx(seq_ep, buffer_selector_state[seq_ep]);
        seq_wdata      = mem_rdata;
        // Software may write the selector when no job touches it
        if (wr_select) begin
            next_select = reg_wdata[uebs_pkg::NUM_PHYS-1:0];
        end
        // New abort requests are ored in; software cannot cancel one
        if (wr_abort) begin
            next_abort = endpoint_abort_request
                       | reg_wdata[uebs_pkg::ABORT_W-1:0];
        end
        case (seq_state)
            uebs_pkg::SEQ_IDLE: begin
                // Count-zero work first, it comes from live traffic
                for (int i = uebs_pkg::NUM_PHYS - 1; i >= 0; i--) begin
                    if (zero_pend[i]) begin
                        next_seq_ep    = 4'(i);
                        next_seq_abort = 1'b0;
                        next_seq_state = uebs_pkg::SEQ_READ;
                    end
                end
                if (zero_pend == '0) begin
                    for (int i = uebs_pkg::NUM_PHYS - 1; i >= 0; i--) begin
                        if (endpoint_abort_request[i]) begin
                            next_seq_ep    = 4'(i);
                            next_seq_abort = 1'b1;
                            next_seq_state = uebs_pkg::SEQ_READ;
                        end
                    end
                end
            end
            uebs_pkg::SEQ_READ: begin
                // Address presented, data registered next cycle
                next_seq_state = uebs_pkg::SEQ_WAIT;
            end
            uebs_pkg::SEQ_WAIT: begin
                next_seq_state = uebs_pkg::SEQ_WRITE;
            end
            uebs_pkg::SEQ_WRITE: begin
                // Disarm entry in list memory
                seq_wdata[uebs_pkg::ARMED_BIT] = 1'b0;
                seq_wr         = 1'b1;
                if (entry.armed) begin
                    disarm_evt[seq_ep] = 1'b1;
                    next_done[seq_ep]  = 1'b1;
                    // Toggle only for double-buffered endpoints
                    if (buffer_mode_config[seq_ep]) begin
                        next_select[seq_ep] = ~buffer_selector_state[seq_ep];
                    end
                end
                if (seq_abort) begin
                    // Abort bit drops only now; a fresh request here wins
                    next_abort[seq_ep]  = wr_abort & reg_wdata[seq_ep];
                    next_select[seq_ep] = buffer_selector_state[seq_ep];
                    // Any abort still sets the endpoint flag even if unarmed
                    disarm_evt[seq_ep]  = 1'b1;
                end else begin
                    next_zero_pend[seq_ep] = link_evt.count_zero[seq_ep];
                end
                next_seq_state = uebs_pkg::SEQ_IDLE;
            end
            default: begin
                next_seq_state = uebs_pkg::SEQ_IDLE;
            end
        endcase
        // Endpoint 0 pair is always single buffered
        next_select[uebs_pkg::FIRST_DBL-1:0] = 2'b00;
    end

    // Register writes and read mux
    always_comb begin
        next_mode    = buffer_mode_config;
        next_enables = endpoint_flag_enables;
        next_nak     = nak_notify;
        next_rdata   = uebs_pkg::RESET_WORD;
        if (reg_write && hit(reg_addr, uebs_pkg::ADDR_MODE)) begin
            next_mode = reg_wdata[uebs_pkg::NUM_PHYS-1:0];
        end
        if (reg_write && hit(reg_addr, uebs_pkg::ADDR_ENABLES)) begin
            next_enables = reg_wdata[uebs_pkg::NUM_PHYS-1:0];
        end
        if (reg_write && hit(reg_addr, uebs_pkg::ADDR_NAKCFG)) begin
            next_nak = reg_wdata[3:0];
        end
        next_mode[uebs_pkg::FIRST_DBL-1:0] = 2'b00;
        if (reg_read) begin
            case (reg_addr)
                uebs_pkg::ADDR_ABORT:   next_rdata = {2'b00, endpoint_abort_request};
                uebs_pkg::ADDR_SELECT:  next_rdata = {22'h000000, buffer_selector_state};
                uebs_pkg::ADDR_MODE:    next_rdata = {22'h000000, buffer_mode_config};
                uebs_pkg::ADDR_FLAGS:   next_rdata = {22'h000000, flag_q};
                uebs_pkg::ADDR_ENABLES: next_rdata = {22'h000000, endpoint_flag_enables};
                uebs_pkg::ADDR_NAKCFG:  next_rdata = {28'h0000000, nak_notify};
                // Unmapped offsets read zero
                default:                next_rdata = uebs_pkg::RESET_WORD;
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            endpoint_abort_request <= uebs_pkg::RESET_ABORT;
            buffer_selector_state  <= uebs_pkg::RESET_PHYS;
            buffer_mode_config     <= uebs_pkg::RESET_PHYS;
            endpoint_flag_enables  <= uebs_pkg::RESET_PHYS;
            nak_notify             <= 4'h0;
            reg_rdata              <= uebs_pkg::RESET_WORD;
            seq_state              <= uebs_pkg::SEQ_IDLE;
            seq_ep                 <= 4'h0;
            seq_abort              <= 1'b0;
            zero_pend              <= uebs_pkg::RESET_PHYS;
            buffer_done            <= uebs_pkg::RESET_PHYS;
        end else begin
            endpoint_abort_request <= next_abort;
            buffer_selector_state  <= next_select;
            buffer_mode_config     <= next_mode;
            endpoint_flag_enables  <= next_enables;
            nak_notify             <= next_nak;
            reg_rdata              <= next_rdata;
            seq_state              <= next_seq_state;
            seq_ep                 <= next_seq_ep;
            seq_abort              <= next_seq_abort;
            zero_pend              <= next_zero_pend;
            buffer_done            <= next_done;
        end
    end
endmodule : uebs_top
`default_nettype wire

// *** tb/uebs_top_sva.sv ***
// Checker for register read-back, done pulses and interrupt gating
`timescale 1ns/1ns
`default_nettype none
module uebs_top_sva (
    input wire logic                          sys_clk,
    input wire logic                          arst_n,
    input wire logic [7:0]                    reg_addr,
    input wire logic [31:0]                   reg_wdata,
    input wire logic                          reg_write,
    input wire logic                          reg_read,
    input wire logic [31:0]                   reg_rdata,
    input wire logic                          irq,
    input wire logic [uebs_pkg::NUM_PHYS-1:0] buffer_done
);
    logic [9:0] en_q;       // Shadow of the enable register
    logic [9:0] next_en_q;  // Its next value
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Follow software writes to the enables
    always_comb begin
        next_en_q = en_q;
        if (reg_write && reg_addr == uebs_pkg::ADDR_ENABLES) begin
            next_en_q = reg_wdata[9:0];
        end
    end
    // Register the shadow
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 10'h000;
        end else begin
            en_q <= next_en_q;
        end
    end
    chk_sel_low_zero: assert property ((reg_read && reg_addr == uebs_pkg::ADDR_SELECT) |=>
        reg_rdata[1:0] == 2'h0) else $error("selector low bits not zero");
    chk_mode_low_zero: assert property ((reg_read && reg_addr == uebs_pkg::ADDR_MODE) |=>
        reg_rdata[1:0] == 2'h0) else $error("mode low bits not zero");
    chk_sel_top_zero: assert property ((reg_read && reg_addr == uebs_pkg::ADDR_SELECT) |=>
        reg_rdata[31:10] == 22'h0) else $error("selector upper bits not zero");
    chk_mode_top_zero: assert property ((reg_read && reg_addr == uebs_pkg::ADDR_MODE) |=>
        reg_rdata[31:10] == 22'h0) else $error("mode upper bits not zero");
    chk_abort_top_zero: assert property ((reg_read && reg_addr == uebs_pkg::ADDR_ABORT) |=>
        reg_rdata[31:30] == 2'h0) else $error("abort reserved bits not zero");
    chk_flag_top_zero: assert property ((reg_read && reg_addr == uebs_pkg::ADDR_FLAGS) |=>
        reg_rdata[31:10] == 22'h0) else $error("flag reserved bits not zero");
    chk_done_one_hot: assert property ($onehot0(buffer_done))
        else $error("two done pulses at once");
    chk_done_gap: assert property ((|buffer_done) |=> buffer_done == 10'h000)
        else $error("done pulse longer than one cycle");
    chk_irq_cause: assert property (irq |-> (en_q != 10'h000 || $past(en_q) != 10'h000))
        else $error("interrupt with no enable set");
    chk_done_irq: assert property (((|(buffer_done & en_q)) && $stable(en_q)) |-> irq)
        else $error("enabled event without interrupt");
endmodule : uebs_top_sva
bind uebs_top uebs_top_sva chk (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .buffer_done(buffer_done));
`default_nettype wire

// *** tb/uebs_link_model.sv ***
// Model of the USB link side: host traffic seen as event pulses
`timescale 1ns/1ns
`default_nettype none
module uebs_link_model (
    input  wire logic                 sys_clk,
    output var  uebs_pkg::uebs_link_s link_evt
);
    initial link_evt = '0;
    // One-cycle pulse; released to zero, the line has no hold
    task automatic pulse(input logic [9:0] cz, input logic [9:0] nak, input logic su);
        @(posedge sys_clk);
        link_evt <= '{count_zero: cz, nak_sent: nak, setup_ok: su};
        @(posedge sys_clk);
        link_evt <= '0;
    endtask : pulse
endmodule : uebs_link_model
`default_nettype wire

// *** tb/uebs_top_test.sv ***
// Self-checking bench for the endpoint buffer status block
`timescale 1ns/1ns
`default_nettype none
module uebs_top_test;
    logic        sys_clk = 1'b0;       // 125 MHz clock
    logic        arst_n = 1'b0;        // Reset, active low
    logic [7:0]  reg_addr = 8'h00;     // Register bus
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        list_wr = 1'b0;       // List memory port
    logic [4:0]  list_addr = 5'h00;
    logic [31:0] list_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        irq;
    logic [9:0]  buffer_done, d;       // Done pulses, collected
    uebs_pkg::uebs_link_s link_evt;    // From the link model
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;           // Timeout counter
    logic [31:0] s = 32'h0651;         // Random state
    logic [9:0]  e;                    // Expected flags
    logic [3:0]  eps [4] = '{4'd0, 4'd1, 4'd6, 4'd9};
    uebs_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .link_evt(link_evt), .list_wr(list_wr), .list_addr(list_addr),
        .list_wdata(list_wdata), .reg_rdata(reg_rdata), .irq(irq),
        .buffer_done(buffer_done));
    uebs_link_model link (.sys_clk(sys_clk), .link_evt(link_evt));
    always #4 sys_clk = ~sys_clk;
    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // Sticky flags: set first, then write-one clears
    function automatic logic [9:0] exp_flags(input logic [9:0] p, st, cl);
        return (p | st) & ~cl;
    endfunction : exp_flags
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    // Read strobe; data stand only the following cycle
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdchk
    // Arm one list entry with a nonzero count
    task automatic arm(input logic [3:0] ep, input logic b);
        @(posedge sys_clk);
        list_wr <= 1'b1;
        list_addr <= {ep, b};
        list_wdata <= 32'h8000_0040;
        @(posedge sys_clk);
        list_wr <= 1'b0;
    endtask : arm
    // Let cycles pass, gathering done pulses
    task automatic idle(input int n);
        d = 10'h000;
        repeat (n) begin
            @(posedge sys_clk);
            #1 d = d | buffer_done;
        end
    endtask : idle
    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        // Start every list entry disarmed so no job reads unknown data
        for (int i = 0; i < 32; i++) begin
            @(posedge sys_clk);
            list_wr <= 1'b1;
            list_addr <= 5'(i);
            list_wdata <= 32'h0;
        end
        @(posedge sys_clk);
        list_wr <= 1'b0;
        foreach (eps[k]) rdchk(8'h14 + 8'(k * 4), 32'h0);
        wr(8'h30, 32'hffff_ffff);
        rdchk(8'h30, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        rdchk(8'h18, 32'h3fc);
        wr(8'h1c, 32'hffff_ffff);
        rdchk(8'h1c, 32'h3fc);
        // Endpoints 2 and 3 double, the rest single
        wr(8'h1c, 32'h00c);
        wr(8'h18, 32'h004);
        arm(4'd2, 1'b1);
        arm(4'd2, 1'b0);
        wr(8'h14, 32'h004);
        rdchk(8'h14, 32'h004);
        idle(8);
        chk(d, 10'h004);
        rdchk(8'h14, 32'h0);
        rdchk(8'h18, 32'h004);
        rdchk(8'h20, 32'h004);
        // Buffer 0 must still be armed
        wr(8'h18, 32'h0);
        wr(8'h14, 32'h004);
        idle(8);
        chk(d, 10'h004);
        // Buffer 0 was written back disarmed: a second abort gives no done
        wr(8'h14, 32'h004);
        idle(8);
        chk(d, 10'h000);
        wr(8'h20, 32'hffff_ffff);
        rdchk(8'h20, 32'h0);
        arm(4'd3, 1'b0);
        link.pulse(10'h008, 10'h0, 1'b0);
        idle(8);
        chk(d, 10'h008);
        rdchk(8'h18, 32'h008);
        arm(4'd4, 1'b0);
        link.pulse(10'h010, 10'h0, 1'b0);
        idle(8);
        chk(d, 10'h010);
        rdchk(8'h18, 32'h008);
        rdchk(8'h20, 32'h018);
        // Control count zero, then aborts queued back to back
        wr(8'h20, 32'hffff_ffff);
        arm(4'd0, 1'b0);
        link.pulse(10'h001, 10'h0, 1'b0);
        wr(8'h14, 32'h3c2);
        idle(40);
        chk(d, 10'h001);
        rdchk(8'h14, 32'h0);
        rdchk(8'h20, 32'h3c3);
        wr(8'h20, 32'hffff_ffff);
        link.pulse(10'h0, 10'h0, 1'b1);
        idle(4);
        rdchk(8'h20, 32'h001);
        // Each NAK option off, then on
        foreach (eps[k]) begin
            wr(8'h2c, 32'h0);
            wr(8'h20, 32'hffff_ffff);
            link.pulse(10'h0, 10'h1 << eps[k], 1'b0);
            idle(4);
            rdchk(8'h20, 32'h0);
            wr(8'h2c, 32'h1 << k);
            link.pulse(10'h0, 10'h1 << eps[k], 1'b0);
            idle(4);
            rdchk(8'h20, 32'h1 << eps[k]);
        end
        wr(8'h24, 32'h200);
        idle(2);
        chk({31'h0, irq}, 32'h1);
        wr(8'h24, 32'h1ff);
        idle(2);
        chk({31'h0, irq}, 32'h0);
        wr(8'h24, 32'h3ff);
        wr(8'h2c, 32'hf);
        wr(8'h20, 32'hffff_ffff);
        e = 10'h000;
        // Random NAK bursts and clears
        repeat (20) begin
            s = xs(s);
            link.pulse(10'h0, s[9:0], 1'b0);
            idle(4);
            e = exp_flags(e, s[9:0], 10'h0);
            s = xs(s);
            wr(8'h20, s);
            e = exp_flags(e, 10'h0, s[9:0]);
            rdchk(8'h20, {22'h0, e});
            chk({31'h0, irq}, {31'h0, |e});
        end
        give_verdict();
    end
endmodule : uebs_top_test
`default_nettype wire
